/* File: include/sinc3_nochop_pkg.sv */
/*
 constants for the sinc3 decimator with input swapping off.
 assumes a 50 MHz mclk_i and a 32.768 kHz modulator stream.
*/
package sinc3_nochop_pkg;
    // ==========================================================
    // filter sizing
    localparam int unsigned MOD_RATE_HZ = 32768;
    localparam int unsigned RATIO_W = 11;
    localparam int unsigned ACC_W = 34;
    localparam int unsigned RESULT_W = 24;
    localparam logic [7:0] DEC_WORD_RESET = 8'h45;
    localparam logic [7:0] DEC_WORD_MIN_OFF = 8'h03;
    localparam logic [7:0] DEC_WORD_MIN_ON = 8'h0D;
    localparam logic [1:0] SETTLE_DISCARD = 2'h2;
    // ==========================================================
    // register map
    localparam logic [7:0] ADDR_DEC_WORD = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_DATA = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam int unsigned CTRL_SWAP_OFF_N_BIT = 0;
    localparam logic CTRL_SWAP_OFF_N_RESET = 1'b1;
    localparam int unsigned STATUS_READY_BIT = 0;
    localparam int unsigned STATUS_SETTLING_BIT = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================================
    // output sequencing
    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_SETTLE = 2'b10
    } settle_state_type;
endpackage : sinc3_nochop_pkg

/* File: rtl/sinc3_core.sv */
/*
 third-order sinc integrator/comb decimator.
 assumes sample_i pulses once per modulator bit, same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module sinc3_core
    import sinc3_nochop_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic clear_i,
    input wire logic sample_i,
    input wire logic bit_i,
    input wire logic [RATIO_W-1:0] ratio_i,
    output logic out_valid_o,
    output logic [ACC_W-1:0] out_data_o
);
    // ==========================================================
    // integrators and comb, wrapping arithmetic is intended
    logic [ACC_W-1:0] i1_reg, i2_reg, i3_reg, d1_reg, d2_reg, d3_reg;
    logic [RATIO_W-1:0] cnt_reg;
    wire [ACC_W-1:0] c1 = i3_reg - d1_reg;
    wire [ACC_W-1:0] c2 = c1 - d2_reg;
    wire [ACC_W-1:0] c3 = c2 - d3_reg;
    // >= so a shrinking ratio never strands the counter
    wire dec_point = sample_i && (cnt_reg >= ratio_i - 1'b1);
    wire [ACC_W-1:0] bit_ext = {{(ACC_W-1){1'b0}}, bit_i};

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {i1_reg, i2_reg, i3_reg} <= '0;
            {d1_reg, d2_reg, d3_reg} <= '0;
            cnt_reg <= '0;
            out_valid_o <= 1'b0;
            out_data_o <= '0;
        end else if (clear_i) begin
            {i1_reg, i2_reg, i3_reg} <= '0;
            {d1_reg, d2_reg, d3_reg} <= '0;
            cnt_reg <= '0;
            out_valid_o <= 1'b0;
        end else begin
            out_valid_o <= dec_point;
            if (sample_i) begin
                i1_reg <= i1_reg + bit_ext; // RULE_05
                i2_reg <= i2_reg + i1_reg;
                i3_reg <= i3_reg + i2_reg;
                cnt_reg <= dec_point ? '0 : cnt_reg + 1'b1; // RULE_06
            end
            if (dec_point) begin
                d1_reg <= i3_reg;
                d2_reg <= c1;
                d3_reg <= c2;
                out_data_o <= c3; // RULE_05
            end
        end
    end

    property p_out_period;
        @(posedge mclk_i) disable iff (!rst_n_i)
        out_valid_o |-> $past(cnt_reg) >= $past(ratio_i) - 1'b1;
    endproperty
    a_out_period: assert property (p_out_period) else $error("early output"); // RULE_06

    property p_clear_history;
        @(posedge mclk_i) disable iff (!rst_n_i)
        clear_i |=> i3_reg == '0 && cnt_reg == '0 && !out_valid_o;
    endproperty
    a_clear_history: assert property (p_clear_history) else $error("history kept"); // RULE_12
endmodule : sinc3_core
`default_nettype wire

/* File: rtl/sinc3_decimator_nochop.sv */
/*
 sinc3 decimator with output sequencing and an AXI4-Lite register slave.
 assumes mod_clk_i/mod_bit_i come from the modulator pins (asynchronous)
 and channel_i comes from logic on mclk_i.
*/
// The placing of the registers and the AXI4-Lite register port were decided locally.
// Functional notes
// RULE_01: swap-off bit 1 gives 16.06 Hz-1.365 kHz
// RULE_02: swap off accepts words 3 to 255
// RULE_03: decimation word resets to 69 (45h)
// RULE_04: effective ratio is eight times the word
// RULE_05: sinc3 filter, one word per period
// RULE_06: rate is modulator rate over ratio
// RULE_07: channel change restarts settling
// RULE_08: sync change: withhold until third result
// RULE_09: unsynced steps keep results flowing
// RULE_10: software recalibrates offset after gain/temperature change
// RULE_11: swap on clamps word below 13 up
// RULE_12: word or swap-bit write resyncs filter
`timescale 1ns/1ps
`default_nettype none
module sinc3_decimator_nochop
    import sinc3_nochop_pkg::*;
#(
    parameter int unsigned CHAN_W = 4
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic mod_clk_i,
    input wire logic mod_bit_i,
    input wire logic [CHAN_W-1:0] channel_i,
    output logic [RESULT_W-1:0] result_o,
    output logic result_valid_o,
    output logic settling_o,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ==========================================================
    // pin synchronisers
    logic mclk_s1_reg, mclk_s2_reg, mclk_s3_reg, bit_s1_reg, bit_s2_reg;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {mclk_s1_reg, mclk_s2_reg, mclk_s3_reg} <= 3'h0;
            {bit_s1_reg, bit_s2_reg} <= 2'h0;
        end else begin
            {mclk_s1_reg, mclk_s2_reg, mclk_s3_reg} <= {mod_clk_i, mclk_s1_reg, mclk_s2_reg};
            {bit_s1_reg, bit_s2_reg} <= {mod_bit_i, bit_s1_reg};
        end
    end
    wire sample = mclk_s2_reg && !mclk_s3_reg;

    // ==========================================================
    // bus write path: address and data are taken in either order
    logic aw_hold_reg, w_hold_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    assign s_axi_awready = !aw_hold_reg;
    assign s_axi_wready = !w_hold_reg;
    wire do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
    wire wr_dec = do_write && aw_addr_reg == ADDR_DEC_WORD && w_strb_reg[0];
    wire wr_ctrl = do_write && aw_addr_reg == ADDR_CTRL && w_strb_reg[0];
    wire wr_mapped = aw_addr_reg == ADDR_DEC_WORD || aw_addr_reg == ADDR_CTRL;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {aw_hold_reg, w_hold_reg, s_axi_bvalid} <= 3'h0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_hold_reg) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_hold_reg) begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                {aw_hold_reg, w_hold_reg, s_axi_bvalid} <= 3'b001;
                s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // control registers and effective ratio
    logic [7:0] dec_word_reg;
    logic swap_off_n_reg;
    logic [CHAN_W-1:0] chan_prev_reg;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dec_word_reg <= DEC_WORD_RESET; // RULE_03
            swap_off_n_reg <= CTRL_SWAP_OFF_N_RESET;
            chan_prev_reg <= '0;
        end else begin
            if (wr_dec) dec_word_reg <= w_data_reg[7:0];
            if (wr_ctrl) swap_off_n_reg <= w_data_reg[CTRL_SWAP_OFF_N_BIT];
            chan_prev_reg <= channel_i;
        end
    end
    // minimum depends on the swap mode; 255 is the top of an 8-bit word
    wire [7:0] word_min = swap_off_n_reg ? DEC_WORD_MIN_OFF : DEC_WORD_MIN_ON; // RULE_01
    wire [7:0] word_eff = dec_word_reg < word_min ? word_min : dec_word_reg; // RULE_02 RULE_11
    wire [RATIO_W-1:0] ratio = {word_eff, 3'b000}; // RULE_04
    wire chan_change = channel_i != chan_prev_reg; // RULE_07
    wire sync_change = chan_change || wr_dec || wr_ctrl; // RULE_12

    // ==========================================================
    // filter
    logic filt_valid;
    logic [ACC_W-1:0] filt_data;
    sinc3_core u_sinc3 (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .clear_i(sync_change),
        .sample_i(sample),
        .bit_i(bit_s2_reg),
        .ratio_i(ratio),
        .out_valid_o(filt_valid),
        .out_data_o(filt_data)
    );
    // top bits only: small ratios leave low-order codes in the result
    wire [RESULT_W-1:0] filt_top = filt_data[ACC_W-1 -: RESULT_W];

    // ==========================================================
    // output sequencing: withhold two outputs after a sync change
    settle_state_type state_reg, state_next;
    logic [1:0] discard_reg;
    logic ready_reg;
    wire deliver = filt_valid && !sync_change && (state_reg == ST_RUN || discard_reg == 2'h0);
    wire rd_data = s_axi_arvalid && !s_axi_rvalid && s_axi_araddr == ADDR_DATA;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: state_next = ST_RUN; // RULE_09
            ST_SETTLE: if (deliver) state_next = ST_RUN;
            default: state_next = ST_SETTLE;
        endcase
        if (sync_change) state_next = ST_SETTLE; // RULE_08
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_SETTLE;
            discard_reg <= SETTLE_DISCARD;
            result_o <= '0;
            result_valid_o <= 1'b0;
            ready_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            result_valid_o <= deliver;
            if (sync_change) begin
                discard_reg <= SETTLE_DISCARD; // RULE_08
            end else if (filt_valid && state_reg == ST_SETTLE && discard_reg != 2'h0) begin
                discard_reg <= discard_reg - 2'h1; // RULE_08
            end
            if (deliver) result_o <= filt_top; // RULE_09
            // a new result in the read cycle keeps the flag set
            ready_reg <= deliver || (ready_reg && !rd_data);
        end
    end
    assign settling_o = state_reg == ST_SETTLE;

    // ==========================================================
    // bus read path
    wire [31:0] rd_mux =
        s_axi_araddr == ADDR_DEC_WORD ? {24'h00_0000, dec_word_reg} :
        s_axi_araddr == ADDR_CTRL ? {31'h0000_0000, swap_off_n_reg} :
        s_axi_araddr == ADDR_DATA ? {8'h00, result_o} :
        {30'h0000_0000, settling_o, ready_reg};
    wire rd_mapped = s_axi_araddr[7:4] == 4'h0 && s_axi_araddr[1:0] == 2'h0;
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mapped ? rd_mux : 32'h0000_0000;
            s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // checks
    sequence s_sync_step;
        sync_change ##1 (state_reg == ST_SETTLE && discard_reg == SETTLE_DISCARD);
    endsequence
    property p_sync_restart;
        @(posedge mclk_i) disable iff (!rst_n_i) sync_change |-> s_sync_step;
    endproperty
    a_sync_restart: assert property (p_sync_restart) else $error("no restart"); // RULE_08
    property p_chan_restart;
        @(posedge mclk_i) disable iff (!rst_n_i) chan_change |=> settling_o;
    endproperty
    a_chan_restart: assert property (p_chan_restart) else $error("channel ignored"); // RULE_07
    property p_withhold;
        @(posedge mclk_i) disable iff (!rst_n_i)
        filt_valid && state_reg == ST_SETTLE && discard_reg != 2'h0 |=> !result_valid_o;
    endproperty
    a_withhold: assert property (p_withhold) else $error("unsettled output"); // RULE_08
    property p_run_flow;
        @(posedge mclk_i) disable iff (!rst_n_i)
        filt_valid && state_reg == ST_RUN && !sync_change
        |=> result_valid_o && result_o == $past(filt_top) && ready_reg;
    endproperty
    a_run_flow: assert property (p_run_flow) else $error("result dropped"); // RULE_09
    property p_min_off;
        @(posedge mclk_i) disable iff (!rst_n_i) swap_off_n_reg |-> ratio >= 11'h018;
    endproperty
    a_min_off: assert property (p_min_off) else $error("ratio under 24"); // RULE_02
    property p_min_on;
        @(posedge mclk_i) disable iff (!rst_n_i) !swap_off_n_reg |-> ratio >= 11'h068;
    endproperty
    a_min_on: assert property (p_min_on) else $error("ratio under 104"); // RULE_11
    property p_word_write;
        @(posedge mclk_i) disable iff (!rst_n_i)
        wr_dec |=> dec_word_reg == $past(w_data_reg[7:0]) && settling_o;
    endproperty
    a_word_write: assert property (p_word_write) else $error("word write lost"); // RULE_12
    property p_reset_word;
        @(posedge mclk_i) $rose(rst_n_i) |-> dec_word_reg == DEC_WORD_RESET;
    endproperty
    a_reset_word: assert property (p_reset_word) else $error("bad reset word"); // RULE_03
    property p_ratio_scale;
        @(posedge mclk_i) disable iff (!rst_n_i)
        dec_word_reg >= DEC_WORD_MIN_ON |-> ratio == {dec_word_reg, 3'b000};
    endproperty
    a_ratio_scale: assert property (p_ratio_scale) else $error("ratio not 8x"); // RULE_04
endmodule : sinc3_decimator_nochop
`default_nettype wire

/* File: verification/test_sinc3_decimator_nochop.sv */
/*
 self-checking bench for the sinc3 decimator: register access over axi4-lite,
 settling, decimation timing and word clamping.
 assumes the package constants and the design's bus timing.
*/
`timescale 1ns/1ps
`default_nettype none
module test_sinc3_decimator_nochop
    import sinc3_nochop_pkg::*;
;
    // ==========================================================
    // signals
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic mod_clk_i = 1'b0;
    logic mod_bit_i = 1'b0;
    logic [3:0] channel_i = 4'h0;
    logic [RESULT_W-1:0] result_o;
    logic result_valid_o;
    logic settling_o;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    int num_errors = 0;
    int samples_checked = 0;
    int sample_cnt = 0;
    int pulse_count = 0;
    int first_at = 0;
    int prev_at = 0;
    int gap_at = 0;
    logic [RESULT_W-1:0] last_result = '0;

    sinc3_decimator_nochop #(.CHAN_W(4)) u_sinc3_decimator_nochop (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .mod_clk_i(mod_clk_i), .mod_bit_i(mod_bit_i),
        .channel_i(channel_i), .result_o(result_o), .result_valid_o(result_valid_o),
        .settling_o(settling_o), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
    );

    initial begin
        forever #10 mclk_i = ~mclk_i;
    end

    // ==========================================================
    // result monitor: sample index of each delivery
    always @(posedge mclk_i) begin
        if (result_valid_o === 1'b1) begin
            if (pulse_count == 0) first_at = sample_cnt;
            else gap_at = sample_cnt - prev_at;
            prev_at = sample_cnt;
            last_result = result_o;
            pulse_count++;
        end
    end

    // ==========================================================
    // tasks
    task stop_test();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    task check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : check

    task hang(input string msg);
        num_errors++;
        $display("unexpected at %0t: timeout %s", $time, msg);
        stop_test();
    endtask : hang

    task axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
            input logic [1:0] exp_resp);
        int n;
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge mclk_i);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge mclk_i);
            if (s_axi_awvalid && s_axi_awready === 1'b1) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready === 1'b1) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
            if (aw_done && w_done && s_axi_bvalid === 1'b1) break;
        end
        if (n == 200) hang("write");
        check({30'h0, s_axi_bresp}, {30'h0, exp_resp}, "bresp");
        s_axi_bready <= 1'b0;
    endtask : axi_write

    task axi_read(input logic [7:0] a, input logic [31:0] exp_d, input logic [1:0] exp_resp);
        int n;
        @(posedge mclk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge mclk_i);
            if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        if (n == 200) hang("read");
        check(s_axi_rdata, exp_d, "rdata");
        check({30'h0, s_axi_rresp}, {30'h0, exp_resp}, "rresp");
        s_axi_rready <= 1'b0;
    endtask : axi_read

    // modulator samples, much faster than the real pin rate; counts stay in samples
    task run(input int n, input logic b);
        int k;
        pulse_count = 0;
        sample_cnt = 0;
        for (k = 0; k < n; k++) begin
            @(posedge mclk_i);
            mod_clk_i <= 1'b1;
            mod_bit_i <= b;
            sample_cnt++;
            repeat (4) @(posedge mclk_i);
            mod_clk_i <= 1'b0;
            repeat (5) @(posedge mclk_i);
        end
    endtask : run

    // ==========================================================
    // main sequence
    initial begin
        repeat (16) @(posedge mclk_i);
        // gain range and temperature stay fixed all run, so no offset calibration is owed
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        #1 check({31'h0, settling_o}, 32'h0000_0001, "settling after reset");
        axi_read(ADDR_DEC_WORD, 32'h0000_0045, RESP_OKAY);
        axi_read(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
        axi_read(8'h10, 32'h0000_0000, RESP_SLVERR);
        axi_write(8'h10, 32'h0000_0007, 4'h1, RESP_SLVERR);
        // smallest legal word: ratio 24, third output after 72 samples
        axi_write(ADDR_DEC_WORD, 32'h0000_0003, 4'h1, RESP_OKAY);
        #1 check({31'h0, settling_o}, 32'h0000_0001, "settling after write");
        run(96, 1'b1);
        check(first_at, 72, "first delivery");
        check(gap_at, 24, "delivery spacing");
        check(pulse_count, 2, "delivery count");
        check({8'h00, last_result}, 32'h0000_000D, "full-scale dc value");
        check({31'h0, settling_o}, 32'h0000_0000, "settled");
        axi_read(ADDR_STATUS, 32'h0000_0001, RESP_OKAY);
        axi_read(ADDR_DATA, 32'h0000_000D, RESP_OKAY);
        axi_read(ADDR_STATUS, 32'h0000_0000, RESP_OKAY);
        // mid-window step: results keep coming, fourth one fully new
        run(12, 1'b1);
        run(84, 1'b0);
        check(pulse_count, 4, "unsynced deliveries");
        check(first_at, 12, "unsynced first");
        check({8'h00, last_result}, 32'h0000_0000, "fourth after step");
        check({31'h0, settling_o}, 32'h0000_0000, "no withholding");
        axi_write(ADDR_DEC_WORD, 32'h0000_0010, 4'h0, RESP_OKAY);
        axi_read(ADDR_DEC_WORD, 32'h0000_0003, RESP_OKAY);
        @(posedge mclk_i);
        channel_i <= 4'h1;
        repeat (2) @(posedge mclk_i);
        #1 check({31'h0, settling_o}, 32'h0000_0001, "channel change");
        // ready stays set from the unread unsynced results; settling shows in bit 1
        axi_read(ADDR_STATUS, 32'h0000_0003, RESP_OKAY);
        run(72, 1'b1);
        check(first_at, 72, "channel settle");
        check(pulse_count, 1, "channel withheld");
        // word below minimum with swapping off counts as 3
        axi_write(ADDR_DEC_WORD, 32'h0000_0001, 4'h1, RESP_OKAY);
        axi_read(ADDR_DEC_WORD, 32'h0000_0001, RESP_OKAY);
        run(72, 1'b1);
        check(first_at, 72, "clamp swap off");
        // swapping on: word 5 counts as 13, ratio 104
        axi_write(ADDR_CTRL, 32'h0000_0000, 4'h1, RESP_OKAY);
        axi_write(ADDR_DEC_WORD, 32'h0000_0005, 4'h1, RESP_OKAY);
        run(312, 1'b1);
        check(first_at, 312, "clamp swap on");
        axi_write(ADDR_CTRL, 32'h0000_0001, 4'h1, RESP_OKAY);
        axi_read(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
        stop_test();
    end
endmodule : test_sinc3_decimator_nochop
`default_nettype wire
